// file: rtl/ebcfg_params.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * external bus configuration block.
 * assumes: included by bare name; offsets are word indices, the apb
 * byte address is four times the index.
 */
`ifndef EBCFG_PARAMS_SVH
`define EBCFG_PARAMS_SVH

`define EBCFG_ADDR_W 18
`define EBCFG_OFS_COMMON 16'hf980
`define EBCFG_OFS_IO_ZONE 16'hf982
`define EBCFG_OFS_STATUS 16'hf990
`define EBCFG_COMMON_RESET 8'h07
`define EBCFG_COMMON_MASK 8'h07
`define EBCFG_IO_RESET 16'h069f
`define EBCFG_IO_MASK 16'h029f
`define EBCFG_BIT_EARLY_WRITE 0
`define EBCFG_BIT_OBSERVE 1
`define EBCFG_BIT_STALL 2
`define EBCFG_WAIT_LSB 0
`define EBCFG_WAIT_MSB 2
`define EBCFG_HOLD_LSB 3
`define EBCFG_HOLD_MSB 4
`define EBCFG_BIT_WIDTH16 7
`define EBCFG_BIT_IDLE_AFTER 9
`define EBCFG_PRE_IDLE_CYCLES 3'h1
`define EBCFG_ACCESS_CYCLES 4'h2

`endif

// file: rtl/ebcfg_pkg.sv
/*
 * types of the external bus configuration block.
 * assumes: nothing beyond the params header.
 */
package ebcfg_pkg;
   typedef enum logic [2:0] {
      CYC_IDLE,
      CYC_PRE_IDLE,
      CYC_ACCESS,
      CYC_WAIT,
      CYC_HOLD,
      CYC_POST_IDLE
   } ebcfg_cycle_t;

   typedef struct packed {
      logic [2:0] wait_cnt;
      logic [1:0] hold_cnt;
      logic width16;
      logic idle_after;
      logic early_write;
   } ebcfg_timing_t;
endpackage : ebcfg_pkg

// file: rtl/ebcfg_io_sequencer.sv
/*
 * io zone bus cycle sequencer: idle, access, waits, holds, trailing idle.
 * assumes: timing snapshot taken at the start of each cycle; one clock.
 */
`include "ebcfg_params.svh"

module ebcfg_io_sequencer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // request side
   input wire logic start,
   input wire logic next_other_zone,
   input wire ebcfg_pkg::ebcfg_timing_t timing,
   // state
   output logic busy,
   output logic drive_addr,
   output logic drive_data,
   output ebcfg_pkg::ebcfg_cycle_t phase
);
   ebcfg_pkg::ebcfg_cycle_t state_reg;
   ebcfg_pkg::ebcfg_timing_t snap_reg;
   logic [3:0] count_reg;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         snap_reg <= '0;
      end else if (state_reg == ebcfg_pkg::CYC_IDLE && start) begin
         snap_reg <= timing;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ebcfg_pkg::CYC_IDLE;
         count_reg <= 4'h0;
      end else begin
         unique case (state_reg)
            ebcfg_pkg::CYC_IDLE: begin
               if (start) begin
                  state_reg <= ebcfg_pkg::CYC_PRE_IDLE;
               end
            end
            ebcfg_pkg::CYC_PRE_IDLE: begin
               state_reg <= ebcfg_pkg::CYC_ACCESS;
               count_reg <= 4'h0;
            end
            ebcfg_pkg::CYC_ACCESS: begin
               if (snap_reg.wait_cnt != 3'h0) begin
                  state_reg <= ebcfg_pkg::CYC_WAIT;
                  count_reg <= {1'b0, snap_reg.wait_cnt};
               end else if (snap_reg.hold_cnt != 2'h0) begin
                  state_reg <= ebcfg_pkg::CYC_HOLD;
                  count_reg <= {2'h0, snap_reg.hold_cnt};
               end else begin
                  state_reg <= ebcfg_pkg::CYC_POST_IDLE;
               end
            end
            ebcfg_pkg::CYC_WAIT: begin
               if (count_reg > 4'h1) begin
                  count_reg <= count_reg - 4'h1;
               end else if (snap_reg.hold_cnt != 2'h0) begin
                  state_reg <= ebcfg_pkg::CYC_HOLD;
                  count_reg <= {2'h0, snap_reg.hold_cnt};
               end else begin
                  state_reg <= ebcfg_pkg::CYC_POST_IDLE;
               end
            end
            ebcfg_pkg::CYC_HOLD: begin
               if (count_reg > 4'h1) begin
                  count_reg <= count_reg - 4'h1;
               end else begin
                  state_reg <= ebcfg_pkg::CYC_POST_IDLE;
               end
            end
            ebcfg_pkg::CYC_POST_IDLE: begin
               if (snap_reg.idle_after && next_other_zone &&
                  count_reg != 4'hf) begin
                  count_reg <= 4'hf;
               end else begin
                  state_reg <= ebcfg_pkg::CYC_IDLE;
                  count_reg <= 4'h0;
               end
            end
         endcase
      end
   end

   assign busy = state_reg != ebcfg_pkg::CYC_IDLE;
   assign phase = state_reg;
   assign drive_addr = state_reg == ebcfg_pkg::CYC_ACCESS ||
      state_reg == ebcfg_pkg::CYC_WAIT || state_reg == ebcfg_pkg::CYC_HOLD;
   assign drive_data = drive_addr;
endmodule : ebcfg_io_sequencer

// file: rtl/ebcfg_top.sv
/*
 * apb register bank for the common bus and io zone settings, plus the
 * io zone cycle timing that those settings steer.
 * assumes: apb master on ref_clk; io requests are single pulses that the
 * requester holds off while io_busy is high (no burst on the io zone).
 */
// Function
// - common configuration resets to 07 hex.
// - bit 0 chooses early write (1) or late write (0).
// - bit 1 lets internal accesses show on external pins.
// - bit 2 stalls internal bus while external bus busy.
// - io zone configuration resets to 069f hex.
// - io bits 2-0 give wait cycles, zero to seven.
// - io bit 7 selects 16-bit (1) or 8-bit (0) data.
// - io bit 9 adds an idle cycle before a different zone.
// - each io cycle starts with one idle cycle; never burst.
// - address and data held through holds, released the cycle after.
`include "ebcfg_params.svh"

module ebcfg_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // internal core side
   input wire logic int_access,
   input wire logic io_start,
   input wire logic io_next_other_zone,
   output logic int_stall,
   output logic obs_enable,
   // io zone pins and status
   output logic io_busy,
   output logic io_addr_drive,
   output logic io_data_drive,
   output logic io_width16,
   output logic io_early_write
);
   logic [7:0] common_reg;
   logic [15:0] io_reg;
   logic seq_busy;
   logic seq_addr;
   logic seq_data;
   ebcfg_pkg::ebcfg_cycle_t seq_phase;
   ebcfg_pkg::ebcfg_timing_t timing;
   logic wr_en;
   logic rd_en;

   // only even indices are used, yet each register sits on the word at index * 4
   function automatic logic hit(input logic [17:0] a, input logic [15:0] o);
      hit = a == {o, 2'b00};
   endfunction : hit

   // write lands at the access edge, where the master sees pready
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         common_reg <= `EBCFG_COMMON_RESET;
         io_reg <= `EBCFG_IO_RESET;
      end else if (wr_en) begin
         if (hit(paddr, `EBCFG_OFS_COMMON)) begin
            common_reg <= pwdata[7:0] & `EBCFG_COMMON_MASK;
         end
         if (hit(paddr, `EBCFG_OFS_IO_ZONE)) begin
            io_reg <= pwdata[15:0] & `EBCFG_IO_MASK;
         end
      end
   end

   // no wait state: setup then access with pready
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         if (rd_en) begin
            pslverr <= !(hit(paddr, `EBCFG_OFS_COMMON) ||
               hit(paddr, `EBCFG_OFS_IO_ZONE) ||
               hit(paddr, `EBCFG_OFS_STATUS));
            if (hit(paddr, `EBCFG_OFS_COMMON)) begin
               prdata <= {24'h00_0000, common_reg};
            end else if (hit(paddr, `EBCFG_OFS_IO_ZONE)) begin
               prdata <= {16'h0000, io_reg};
            end else if (hit(paddr, `EBCFG_OFS_STATUS)) begin
               prdata <= {28'h000_0000, 1'b0, seq_phase};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end else begin
            // error stands only beside pready
            pslverr <= 1'b0;
         end
      end
   end

   assign timing.wait_cnt = io_reg[`EBCFG_WAIT_MSB:`EBCFG_WAIT_LSB];
   assign timing.hold_cnt = io_reg[`EBCFG_HOLD_MSB:`EBCFG_HOLD_LSB];
   assign timing.width16 = io_reg[`EBCFG_BIT_WIDTH16];
   assign timing.idle_after = io_reg[`EBCFG_BIT_IDLE_AFTER];
   assign timing.early_write = common_reg[`EBCFG_BIT_EARLY_WRITE];

   ebcfg_io_sequencer u_seq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(io_start),
      .next_other_zone(io_next_other_zone),
      .timing(timing),
      .busy(seq_busy),
      .drive_addr(seq_addr),
      .drive_data(seq_data),
      .phase(seq_phase)
   );

   // width and write style held per cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         io_width16 <= 1'b1;
         io_early_write <= 1'b1;
      end else if (!seq_busy && io_start) begin
         io_width16 <= timing.width16;
         io_early_write <= timing.early_write;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         io_busy <= 1'b0;
         io_addr_drive <= 1'b0;
         io_data_drive <= 1'b0;
         int_stall <= 1'b0;
         obs_enable <= 1'b0;
      end else begin
         io_busy <= seq_busy;
         io_addr_drive <= seq_addr;
         io_data_drive <= seq_data;
         int_stall <= common_reg[`EBCFG_BIT_STALL] && seq_busy;
         obs_enable <= common_reg[`EBCFG_BIT_OBSERVE] && int_access &&
            !seq_busy;
      end
   end
endmodule : ebcfg_top

// file: verif/ebcfg_top_properties.sv
/* port checks of ebcfg_top: apb answer, io cycle shape, core side.
   assumes: bound to every ebcfg_top instance; one clock domain. */
module ebcfg_top_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // core and io
   input wire logic int_access,
   input wire logic int_stall,
   input wire logic obs_enable,
   input wire logic io_busy,
   input wire logic io_addr_drive,
   input wire logic io_data_drive,
   input wire logic io_width16
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_open;
      $rose(io_busy) ##0 !io_addr_drive;
   endsequence
   sequence s_close;
      io_busy[*3] ##[1:12] !io_busy;
   endsequence
   a_access_ready: assert property (psel && penable |-> pready)
      else $error("apb access got no ready");
   a_err_with_ready: assert property (
      pslverr |-> pready ##1 !pready)
      else $error("error or ready not a single pulse");
   a_pre_idle: assert property ($rose(io_busy) |-> s_open)
      else $error("io cycle lacks leading idle");
   a_cycle_bounded: assert property ($rose(io_busy) |-> s_close)
      else $error("io cycle length out of range");
   a_drive_in_busy: assert property (io_addr_drive |-> io_busy)
      else $error("address driven outside io cycle");
   a_data_release: assert property (
      $fell(io_addr_drive) |-> !io_data_drive && io_busy)
      else $error("data outlives address");
   a_stall_busy: assert property (int_stall |-> io_busy)
      else $error("stall without busy bus");
   a_observe_idle: assert property (
      obs_enable |-> $past(int_access) && !io_busy)
      else $error("observe without idle internal access");
   a_width_stable: assert property (io_busy |-> $stable(io_width16))
      else $error("width changed inside io cycle");
endmodule : ebcfg_top_chk
bind ebcfg_top ebcfg_top_chk u_chk (.ref_clk, .sys_rst, .psel, .penable,
   .pready, .pslverr, .int_access, .int_stall, .obs_enable, .io_busy,
   .io_addr_drive, .io_data_drive, .io_width16);

// file: verif/ebcfg_io_dev.sv
/* io expansion device model: counts busy and address cycles.
   assumes: fed by the io pins of ebcfg_top on ref_clk. */
module ebcfg_io_dev (
   // clock and control
   input wire logic ref_clk,
   input wire logic clr,
   // io pins
   input wire logic io_busy,
   input wire logic io_addr_drive,
   // counts
   output logic [7:0] busy_cnt,
   output logic [7:0] addr_cnt
);
   always_ff @(posedge ref_clk) begin
      busy_cnt <= clr ? 8'h00 : busy_cnt + 8'(io_busy);
      addr_cnt <= clr ? 8'h00 : addr_cnt + 8'(io_addr_drive);
   end
endmodule : ebcfg_io_dev

// file: verif/ext_bus_common_and_io_zone_cfg_tb_top.sv
/* bench of ebcfg_top: apb reads and writes, io cycle lengths.
   assumes: ebcfg_top, checker and device model compiled before. */
`include "ebcfg_params.svh"
module ext_bus_common_and_io_zone_cfg_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = 18'h0_0000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, int_access = 0, io_start = 0, nxt = 0;
   logic clr = 0, seen = 0, int_stall, obs_enable, io_busy, io_addr_drive;
   logic io_data_drive, io_width16, io_early_write;
   logic [7:0] busy_cnt, addr_cnt, b0, a0;
   logic [31:0] tv [3] = '{32'h1b, 32'h05, 32'h12};
   int mismatches = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) seen <= clr ? 1'b0 : (seen | int_stall);
   ebcfg_top DUT (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .int_access, .io_start,
      .io_next_other_zone(nxt), .int_stall, .obs_enable, .io_busy,
      .io_addr_drive, .io_data_drive, .io_width16, .io_early_write);
   ebcfg_io_dev u_dev (.ref_clk, .clr, .io_busy, .io_addr_drive,
      .busy_cnt, .addr_cnt);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [15:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {a, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic io_go(input logic c);
      @(posedge ref_clk);
      clr <= c;
      io_start <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      io_start <= 1'b0;
   endtask : io_go
   task automatic io_done();
      int n = 0;
      while (io_busy !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         n++;
      end
      if (io_busy !== 1'b1) mismatches++;
      while (io_busy !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 40) mismatches++;
      @(posedge ref_clk);
   endtask : io_done
   task automatic results();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   initial begin
      #200us;
      mismatches++;
      results();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      apb(1'b0, `EBCFG_OFS_COMMON, 32'h0); chk(rd, 32'h07);
      apb(1'b0, `EBCFG_OFS_IO_ZONE, 32'h0); chk(rd, 32'h069f);
      apb(1'b0, `EBCFG_OFS_STATUS, 32'h0);
      chk(rd, 32'(ebcfg_pkg::CYC_IDLE));
      apb(1'b0, 16'hf9a0, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `EBCFG_OFS_IO_ZONE, 32'hffff_ffff);
      apb(1'b0, `EBCFG_OFS_IO_ZONE, 32'h0); chk(rd, 32'h029f);
      apb(1'b1, `EBCFG_OFS_COMMON, 32'hffff_ffff);
      apb(1'b0, `EBCFG_OFS_COMMON, 32'h0); chk(rd, 32'h07);
      io_go(1'b1); io_done(); chk(seen, 1'b1);
      chk(io_early_write, 1'b1);
      int_access <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(obs_enable, 1'b1);
      apb(1'b1, `EBCFG_OFS_COMMON, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk(obs_enable, 1'b0);
      int_access <= 1'b0;
      apb(1'b1, `EBCFG_OFS_IO_ZONE, 32'h0);
      io_go(1'b1); io_done(); chk(seen, 1'b0);
      chk({io_width16, io_early_write}, 2'b00);
      // bare cycle: leading idle, access, trailing idle
      chk(busy_cnt, 32'h3);
      chk(addr_cnt, 32'h1);
      b0 = 8'h03;
      a0 = 8'h01;
      foreach (tv[i]) begin
         apb(1'b1, `EBCFG_OFS_IO_ZONE, tv[i]);
         io_go(1'b1); io_done();
         chk(addr_cnt, a0 + tv[i][2:0] + tv[i][4:3]);
         chk(busy_cnt, b0 + tv[i][2:0] + tv[i][4:3]);
      end
      apb(1'b1, `EBCFG_OFS_IO_ZONE, 32'h0200);
      nxt <= 1'b1;
      io_go(1'b1); io_done(); chk(busy_cnt, b0 + 1);
      nxt <= 1'b0;
      io_go(1'b1); io_done(); chk(busy_cnt, b0);
      apb(1'b1, `EBCFG_OFS_IO_ZONE, 32'h0087);
      io_go(1'b1);
      apb(1'b1, `EBCFG_OFS_IO_ZONE, 32'h0);
      apb(1'b0, `EBCFG_OFS_STATUS, 32'h0);
      chk(rd, 32'(ebcfg_pkg::CYC_WAIT));
      io_go(1'b0); io_done(); chk(busy_cnt, b0 + 7);
      chk(io_width16, 1'b1);
      results();
   end
endmodule : ext_bus_common_and_io_zone_cfg_tb_top
